// ### hw/jsb_instr_ext.v
// jsb_instr_ext.v: test access port with block access, abort, clock ratio,
// domain reset, full erase and cpu hold instructions on a service bus
// assumes: tck/tms/tdi come from pins and are far slower than pclk;
// the service bus answers every taken request once, in order
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "jsb_regs.vh"

// Function
// (RQ1) block mode steps address, repeats direction
// (RQ2) debugger sets address before block mode
// (RQ3) block code 10010, 34-bit register
// (RQ4) writes shift all 32 bits
// (RQ5) one update per block element
// (RQ6) cancel code 10011 aborts, reports timeout
// (RQ7) new command only once busy clears
// (RQ8) sync 10111 counts 16-bit value down
// (RQ9) debugger polls busy after sync load
// (RQ10) domain reset bits hold domains reset
// (RQ11) debugger shifts every domain bit
// (RQ12) erase 01111 starts erase, clears security
// (RQ13) erase capture pattern shows busy
// (RQ14) no nonvolatile memory: erase completes at once
// (RQ15) programmer halts cpu around erase
// (RQ16) hold code 11100 resets, holds cpu
// (RQ17) debugger holds cpu while programming
// (RQ18) access starts in address mode, toggles
// (RQ19) access capture shows error until success
module jsb_instr_ext #(
  parameter DOMAINS = 5,
  parameter FIFO_DEPTH = 2,
  parameter FIFO_AW = 1
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg tdo,
  output reg tdo_oe,
  output wire sb_req_valid,
  input wire sb_req_ready,
  output wire [35:0] sb_req_addr,
  output wire [1:0] sb_req_size,
  output wire sb_req_write,
  output wire [31:0] sb_req_wdata,
  output wire sb_abort,
  input wire sb_rsp_valid,
  output wire sb_rsp_ready,
  input wire [31:0] sb_rsp_rdata,
  input wire sb_rsp_err,
  input wire protect,
  input wire nvm_erase_done,
  output reg [DOMAINS-1:0] domain_reset,
  output reg cpu_hold,
  output reg sys_reset,
  output reg erase_start,
  output reg sec_clear
);

  // ********************************************************
  // tap states and helpers
  // ********************************************************
  localparam S_TLR = 4'h0, S_RTI = 4'h1, S_SDS = 4'h2, S_CDR = 4'h3;
  localparam S_SDR = 4'h4, S_E1D = 4'h5, S_PDR = 4'h6, S_E2D = 4'h7;
  localparam S_UDR = 4'h8, S_SIS = 4'h9, S_CIR = 4'ha, S_SIR = 4'hb;
  localparam S_E1I = 4'hc, S_PIR = 4'hd, S_E2I = 4'he, S_UIR = 4'hf;
  localparam FW = 71;

  function [3:0] tap_next;
    input [3:0] st;
    input m;
    begin
      case (st)
        S_TLR: tap_next = m ? S_TLR : S_RTI;
        S_RTI: tap_next = m ? S_SDS : S_RTI;
        S_SDS: tap_next = m ? S_SIS : S_CDR;
        S_CDR: tap_next = m ? S_E1D : S_SDR;
        S_SDR: tap_next = m ? S_E1D : S_SDR;
        S_E1D: tap_next = m ? S_UDR : S_PDR;
        S_PDR: tap_next = m ? S_E2D : S_PDR;
        S_E2D: tap_next = m ? S_UDR : S_SDR;
        S_UDR: tap_next = m ? S_SDS : S_RTI;
        S_SIS: tap_next = m ? S_TLR : S_CIR;
        S_CIR: tap_next = m ? S_E1I : S_SIR;
        S_SIR: tap_next = m ? S_E1I : S_SIR;
        S_E1I: tap_next = m ? S_UIR : S_PIR;
        S_PIR: tap_next = m ? S_E2I : S_PIR;
        S_E2I: tap_next = m ? S_UIR : S_SIR;
        S_UIR: tap_next = m ? S_SDS : S_RTI;
        default: tap_next = S_TLR;
      endcase
    end
  endfunction

  // byte step of an access size: byte, halfword, word
  function [35:0] step_of;
    input [1:0] sz;
    begin
      case (sz)
        2'h0: step_of = 36'h000000001;
        2'h1: step_of = 36'h000000002;
        default: step_of = 36'h000000004;
      endcase
    end
  endfunction

  function [5:0] dr_len_of;
    input [4:0] code;
    begin
      case (code)
        `JSB_IR_WORD: dr_len_of = `JSB_LEN_WORD;
        `JSB_IR_SIZED: dr_len_of = `JSB_LEN_SIZED;
        `JSB_IR_BLOCK: dr_len_of = `JSB_LEN_BLOCK; // RQ3
        `JSB_IR_SYNC: dr_len_of = `JSB_LEN_SYNC;
        `JSB_IR_DOMRST: dr_len_of = DOMAINS[5:0];
        default: dr_len_of = `JSB_LEN_ONE;
      endcase
    end
  endfunction

  // ********************************************************
  // declarations
  // ********************************************************
  reg tck_m, tck_s, tck_d, tms_m, tms_s, tdi_m, tdi_s;
  reg [3:0] state;
  reg [4:0] ir, ir_sh;
  reg [38:0] dr, dr_sh, dr_cap;
  reg [1:0] ctrl;
  reg data_mode, dir_rd, last_rd, abort_pend, erase_busy, err;
  reg [35:0] addr;
  reg [1:0] size;
  reg push_q;
  reg [FW-1:0] push_data;
  reg [31:0] rdata;
  reg [15:0] sync_cnt;
  reg [1:0] outst;
  reg [FW-1:0] mem [0:FIFO_DEPTH-1];
  reg [FIFO_AW:0] wptr, rptr;
  reg [31:0] next_prdata;
  reg next_pslverr;
  wire port_en, rise, fall, upd_dr, upd_ir, acc_ok, acc_busy, sync_busy;
  wire empty, full, push, pop, rsp, cancel_go;
  wire [35:0] blk_addr;
  wire [5:0] len;

  assign port_en = ctrl[`JSB_CTRL_PORT_EN];
  assign rise = port_en & tck_s & ~tck_d;
  assign fall = port_en & ~tck_s & tck_d;
  assign upd_dr = rise && (state == S_UDR);
  assign upd_ir = rise && (state == S_UIR);
  assign cancel_go = upd_ir && (ir_sh == `JSB_IR_CANCEL);
  // posted writes block only while push_q waits, the buffer is full or an abort is pending; reads block until answered
  assign acc_busy = push_q | full | abort_pend | (last_rd & (~empty | (outst != 2'h0)));
  assign acc_ok = ~acc_busy; // RQ7
  assign sync_busy = (sync_cnt != 16'h0000);
  assign blk_addr = addr + step_of(size); // RQ1
  assign len = dr_len_of(ir);

  // ********************************************************
  // pin synchronisers and edge detect
  // ********************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tck_m <= 1'b0;
      tck_s <= 1'b0;
      tck_d <= 1'b0;
      tms_m <= 1'b1;
      tms_s <= 1'b1;
      tdi_m <= 1'b0;
      tdi_s <= 1'b0;
    end else begin
      tck_m <= tck;
      tck_s <= tck_m;
      tck_d <= tck_s;
      tms_m <= tms;
      tms_s <= tms_m;
      tdi_m <= tdi;
      tdi_s <= tdi_m;
    end
  end

  // ********************************************************
  // capture and shift values
  // ********************************************************
  always @* begin
    dr_sh = dr >> 1;
    dr_sh[len - 6'h01] = tdi_s;
    dr_cap = 39'h0;
    case (ir)
      `JSB_IR_WORD, `JSB_IR_SIZED: begin
        if (data_mode)
          dr_cap[33:0] = {err, acc_busy, rdata};
        else
          dr_cap[1:0] = {err, acc_busy};
      end
      `JSB_IR_BLOCK: dr_cap[33:0] = {err, acc_busy, rdata}; // RQ3
      `JSB_IR_SYNC: dr_cap[1:0] = {err, sync_busy};
      `JSB_IR_DOMRST: dr_cap[DOMAINS-1:0] = domain_reset;
      `JSB_IR_HALT: dr_cap[0] = cpu_hold; // RQ16
      default: dr_cap = 39'h0; // RQ6
    endcase
  end

  // ********************************************************
  // tap controller and instruction actions
  // ********************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_TLR;
      ir <= `JSB_IR_BYPASS;
      ir_sh <= 5'h00;
      dr <= 39'h0;
      data_mode <= 1'b0;
      addr <= 36'h0;
      size <= `JSB_SIZE_WORD;
      dir_rd <= 1'b0;
      last_rd <= 1'b0;
      push_q <= 1'b0;
      push_data <= {FW{1'b0}};
      abort_pend <= 1'b0;
      domain_reset <= {DOMAINS{1'b0}};
      cpu_hold <= 1'b0;
      sys_reset <= 1'b0;
      erase_start <= 1'b0;
      sec_clear <= 1'b0;
      erase_busy <= 1'b0;
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      sys_reset <= 1'b0;
      erase_start <= 1'b0;
      sec_clear <= 1'b0;
      if (push_q && !full)
        push_q <= 1'b0;
      // abort holds until every taken access has answered
      if (abort_pend && outst == 2'h0)
        abort_pend <= 1'b0;
      if (nvm_erase_done)
        erase_busy <= 1'b0;
      if (fall) begin
        tdo <= (state == S_SDR) ? dr[0] : ir_sh[0];
        tdo_oe <= (state == S_SDR) || (state == S_SIR);
      end
      if (rise) begin
        state <= tap_next(state, tms_s);
        case (state)
          S_TLR: begin
            ir <= `JSB_IR_BYPASS;
            data_mode <= 1'b0;
          end
          S_CIR: begin
            if (ir == `JSB_IR_ERASE)
              ir_sh <= {protect, 1'b0, erase_busy, 2'b01}; // RQ13
            else if (ir == `JSB_IR_DOMRST || ir == `JSB_IR_HALT || ir == `JSB_IR_BYPASS)
              ir_sh <= {protect, 4'b0001};
            else
              ir_sh <= {protect, err, acc_busy, 2'b01}; // RQ19
          end
          S_SIR: ir_sh <= {tdi_s, ir_sh[4:1]};
          S_CDR: dr <= dr_cap;
          S_SDR: dr <= dr_sh;
          S_UIR: begin
            ir <= ir_sh;
            if (ir_sh == `JSB_IR_WORD || ir_sh == `JSB_IR_SIZED)
              data_mode <= 1'b0; // RQ18
            if (cancel_go && (!empty || outst != 2'h0 || push_q)) begin
              abort_pend <= 1'b1; // RQ6
              push_q <= 1'b0;
            end
            // block read: fetch the next location ahead of the first scan
            if (ir_sh == `JSB_IR_BLOCK && dir_rd && acc_ok) begin
              addr <= blk_addr; // RQ1
              push_q <= 1'b1;
              push_data <= {blk_addr, size, 1'b0, 32'h0};
              last_rd <= 1'b1;
            end
            if (ir_sh == `JSB_IR_ERASE && ctrl[`JSB_CTRL_NVM]) begin // RQ14
              erase_start <= 1'b1; // RQ12
              sec_clear <= 1'b1;
              erase_busy <= 1'b1;
            end
          end
          S_UDR: begin
            case (ir)
              `JSB_IR_WORD, `JSB_IR_SIZED: begin
                if (acc_ok) begin
                  data_mode <= ~data_mode; // RQ18
                  if (!data_mode) begin
                    if (ir == `JSB_IR_WORD) begin
                      addr <= {dr[34:1], 2'b00};
                      size <= `JSB_SIZE_WORD;
                    end else begin
                      addr <= dr[38:3];
                      size <= dr[2:1];
                    end
                    dir_rd <= dr[0];
                    if (dr[0]) begin
                      push_q <= 1'b1;
                      last_rd <= 1'b1;
                      if (ir == `JSB_IR_WORD)
                        push_data <= {dr[34:1], 2'b00, `JSB_SIZE_WORD, 1'b0, 32'h0};
                      else
                        push_data <= {dr[38:3], dr[2:1], 1'b0, 32'h0};
                    end
                  end else if (!dir_rd) begin
                    push_q <= 1'b1;
                    last_rd <= 1'b0;
                    push_data <= {addr, size, 1'b1, dr[31:0]};
                  end
                end
              end
              `JSB_IR_BLOCK: begin
                // each element: step, then repeat the same direction
                if (acc_ok) begin
                  addr <= blk_addr; // RQ1
                  push_q <= 1'b1;
                  last_rd <= dir_rd;
                  push_data <= {blk_addr, size, ~dir_rd, dir_rd ? 32'h0 : dr[31:0]};
                end
              end
              `JSB_IR_DOMRST: domain_reset <= dr[DOMAINS-1:0]; // RQ10
              `JSB_IR_HALT: begin
                cpu_hold <= dr[0]; // RQ16
                sys_reset <= 1'b1;
              end
              default: dr <= dr;
            endcase
          end
          default: dr <= dr;
        endcase
      end
    end
  end

  // ********************************************************
  // clock ratio counter
  // ********************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sync_cnt <= 16'h0000;
    else if (upd_dr && ir == `JSB_IR_SYNC)
      sync_cnt <= dr[15:0]; // RQ8
    else if (sync_busy)
      sync_cnt <= sync_cnt - 16'h0001; // RQ8
  end

  // ********************************************************
  // two-entry request buffer
  // ********************************************************
  // fill side stalls on full with push_q waiting, drain side on sb_req_ready, abort_pend or three outstanding
  assign empty = (wptr == rptr);
  assign full = (wptr[FIFO_AW] != rptr[FIFO_AW]) && (wptr[FIFO_AW-1:0] == rptr[FIFO_AW-1:0]);
  assign push = push_q & ~full;
  assign sb_req_valid = ~empty & ~abort_pend & (outst != 2'h3);
  assign pop = sb_req_valid & sb_req_ready;
  assign {sb_req_addr, sb_req_size, sb_req_write, sb_req_wdata} = mem[rptr[FIFO_AW-1:0]];
  assign sb_abort = abort_pend; // RQ6

  always @(posedge pclk) begin
    if (push)
      mem[wptr[FIFO_AW-1:0]] <= push_data;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr <= {(FIFO_AW+1){1'b0}};
      rptr <= {(FIFO_AW+1){1'b0}};
    end else begin
      if (push)
        wptr <= wptr + 1'b1;
      // a cancel drops all queued requests that the bus has not taken
      if (cancel_go)
        rptr <= push ? wptr + 1'b1 : wptr; // RQ6
      else if (pop)
        rptr <= rptr + 1'b1;
    end
  end

  // ********************************************************
  // outstanding accesses, read data and error flag
  // ********************************************************
  assign sb_rsp_ready = 1'b1;
  assign rsp = sb_rsp_valid & (outst != 2'h0);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      outst <= 2'h0;
      rdata <= 32'h0;
      err <= 1'b0;
    end else begin
      outst <= outst + {1'b0, pop} - {1'b0, rsp};
      if (rsp && !abort_pend)
        rdata <= sb_rsp_rdata;
      // set wins over the clear of a new access
      if ((rsp && sb_rsp_err) || cancel_go)
        err <= 1'b1; // RQ19
      else if (pop)
        err <= 1'b0;
    end
  end

  // ********************************************************
  // apb slave
  // ********************************************************
  assign pready = 1'b1;

  always @* begin
    next_prdata = 32'h0;
    next_pslverr = 1'b0;
    case (paddr)
      `JSB_OFF_CTRL: next_prdata = {30'h0, ctrl};
      `JSB_OFF_STATUS: next_prdata = {12'h0, addr[35:32], 3'h0, ir, 2'h0, data_mode, cpu_hold,
                                      erase_busy, sync_busy, err, acc_busy};
      `JSB_OFF_ADDR: next_prdata = addr[31:0];
      `JSB_OFF_SYNC: next_prdata = {16'h0, sync_cnt};
      default: next_pslverr = 1'b1;
    endcase
  end

  // read data registered in the setup cycle, so no wait states are needed
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
      ctrl <= `JSB_CTRL_RST;
    end else begin
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0 : next_prdata;
        pslverr <= next_pslverr;
      end
      if (psel && penable && pwrite && paddr == `JSB_OFF_CTRL)
        ctrl <= pwdata[1:0]; // RQ14
    end
  end

endmodule // jsb_instr_ext

// ### hw/jsb_regs.vh
// jsb_regs.vh: constants of the test-port service bus instruction block
// assumes: included by jsb_instr_ext.v and the test bench; definitions only, no logic
`ifndef JSB_REGS_VH
`define JSB_REGS_VH

// ********************************************************
// instruction codes
// ********************************************************
`define JSB_IR_WORD 5'h11
`define JSB_IR_BLOCK 5'h12
`define JSB_IR_CANCEL 5'h13
`define JSB_IR_SIZED 5'h15
`define JSB_IR_SYNC 5'h17
`define JSB_IR_DOMRST 5'h0c
`define JSB_IR_ERASE 5'h0f
`define JSB_IR_HALT 5'h1c
`define JSB_IR_BYPASS 5'h1f

// ********************************************************
// data register lengths
// ********************************************************
`define JSB_LEN_WORD 6'h23
`define JSB_LEN_SIZED 6'h27
`define JSB_LEN_BLOCK 6'h22
`define JSB_LEN_SYNC 6'h10
`define JSB_LEN_ONE 6'h01
`define JSB_SIZE_WORD 2'h2

// ********************************************************
// apb register offsets and reset values
// ********************************************************
`define JSB_OFF_CTRL 12'h000
`define JSB_OFF_STATUS 12'h004
`define JSB_OFF_ADDR 12'h008
`define JSB_OFF_SYNC 12'h00c
`define JSB_CTRL_RST 2'h3
`define JSB_CTRL_PORT_EN 0
`define JSB_CTRL_NVM 1

`endif

// ### sim/jsb_instr_ext_assertions.sv
// jsb_instr_ext_assertions.sv: checker on the service bus and control pulses
// assumes: bound to jsb_instr_ext, sees only its ports, single pclk domain
`timescale 1ns/1ps
module jsb_instr_ext_assertions (
  input wire pclk,
  input wire presetn,
  input wire sb_req_valid,
  input wire sb_req_ready,
  input wire [35:0] sb_req_addr,
  input wire sb_req_write,
  input wire sb_abort,
  input wire sb_rsp_valid,
  input wire erase_start,
  input wire sec_clear,
  input wire sys_reset,
  input wire cpu_hold
);
  // ********
  // outstanding count
  // ********
  logic [2:0] outstanding;
  wire [2:0] next_outstanding = outstanding + {2'h0, sb_req_valid & sb_req_ready} - {2'h0, sb_rsp_valid};
  // counted at the ports, so a stale count inside the block shows up
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      outstanding <= 3'h0;
    end else begin
      outstanding <= next_outstanding;
    end
  end
  // ********
  // properties
  // ********
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_erase_pulse;
    erase_start && sec_clear ##1 !erase_start && !sec_clear;
  endsequence
  sequence s_reset_pulse;
    sys_reset ##1 !sys_reset;
  endsequence
  chk_erase_pair: assert property ($rose(erase_start) |-> s_erase_pulse)
    else $error("erase start and security clear not one joint pulse");
  chk_halt_pulse: assert property ($rose(sys_reset) |-> s_reset_pulse)
    else $error("device reset pulse not one cycle");
  chk_hold_resets: assert property ($changed(cpu_hold) |-> sys_reset)
    else $error("cpu hold changed without a device reset");
  chk_abort_blocks: assert property (sb_abort |-> !sb_req_valid)
    else $error("request offered during abort");
  chk_abort_drains: assert property ($fell(sb_abort) |-> outstanding == 3'h0)
    else $error("abort ended with answers still due");
  chk_abort_holds: assert property (sb_abort && outstanding > 3'h0 |=> sb_abort)
    else $error("abort dropped too early");
  chk_outstanding_cap: assert property (sb_req_valid |-> outstanding < 3'h3)
    else $error("more than three requests outstanding");
  chk_req_hold: assert property (sb_req_valid && !sb_req_ready |=>
    !sb_req_valid || ($stable(sb_req_addr) && $stable(sb_req_write)))
    else $error("request fields changed while waiting");
endmodule // jsb_instr_ext_assertions

bind jsb_instr_ext jsb_instr_ext_assertions u_chk (.pclk, .presetn, .sb_req_valid, .sb_req_ready,
  .sb_req_addr, .sb_req_write, .sb_abort, .sb_rsp_valid, .erase_start, .sec_clear, .sys_reset, .cpu_hold);

// ### sim/jsb_instr_ext_tb_top.sv
// jsb_instr_ext_tb_top.sv: self-checking bench, apb and test-port tasks
// assumes: jsb_sbus_model on the service bus; checker bound from its own file
`timescale 1ns/1ps
`include "jsb_regs.vh"
module jsb_instr_ext_tb_top;
  logic pclk, presetn, psel, penable, pwrite, tck, tms, tdi, protect, nvm_erase_done, stall, slow, err, tdo_s;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [38:0] so;
  int fails, num_checks, cyc, erase_cnt, rst_cnt, e0;
  wire pready, pslverr, tdo, sb_req_valid, sb_req_ready, sb_req_write, sb_abort, sb_rsp_valid, sb_rsp_err;
  wire cpu_hold, sys_reset, erase_start, sec_clear, tdo_oe, sb_rsp_ready;
  wire [31:0] prdata, sb_req_wdata, sb_rsp_rdata, last_wdata;
  wire [35:0] sb_req_addr, last_addr;
  wire [1:0] sb_req_size;
  wire [4:0] domain_reset;
  jsb_instr_ext DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .tck, .tms, .tdi, .tdo, .tdo_oe, .sb_req_valid, .sb_req_ready, .sb_req_addr, .sb_req_size, .sb_req_write,
    .sb_req_wdata, .sb_abort, .sb_rsp_valid, .sb_rsp_ready, .sb_rsp_rdata, .sb_rsp_err, .protect,
    .nvm_erase_done, .domain_reset, .cpu_hold, .sys_reset, .erase_start, .sec_clear);
  jsb_sbus_model u_bus (.pclk, .presetn, .stall, .slow, .sb_req_valid, .sb_req_ready, .sb_req_addr,
    .sb_req_write, .sb_req_wdata, .sb_rsp_valid, .sb_rsp_rdata, .sb_rsp_err, .last_addr, .last_wdata);
  // ********
  // clock, pulse counts, hang guard
  // ********
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // security bits clear on the erase pulse, as the memory would
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (erase_start === 1'b1) erase_cnt <= erase_cnt + 1;
    if (sys_reset === 1'b1) rst_cnt <= rst_cnt + 1;
    if (sec_clear === 1'b1) protect <= 1'b0;
    if (cyc == 40000) begin
      fails = fails + 1;
      print_verdict();
    end
  end
  // ********
  // tasks
  // ********
  // wide enough for a full bus address next to a data word
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one test clock of 800 ns; tck stands still between calls
  task automatic tk(input logic m, input logic i);
    @(posedge pclk);
    tck <= 1'b0;
    tms <= m;
    tdi <= i;
    repeat (4) @(posedge pclk);
    tck <= 1'b1;
    repeat (3) @(posedge pclk);
    tdo_s = tdo;
  endtask
  // full scan from idle back to idle, every bit shifted
  task automatic scan(input logic ir, input int n, input logic [38:0] din);
    so = 39'h0;
    tk(1'b1, 1'b0);
    if (ir) tk(1'b1, 1'b0);
    tk(1'b0, 1'b0);
    tk(1'b0, 1'b0);
    for (int k = 0; k < n; k++) begin
      tk(k == n - 1, din[k]);
      so[k] = tdo_s;
      if (k == 0) chk(tdo_oe, 1'b1);
    end
    tk(1'b1, 1'b0);
    tk(1'b0, 1'b0);
    repeat (6) @(posedge pclk);
    chk(tdo_oe, 1'b0);
  endtask
  task automatic ir(input logic [4:0] c);
    scan(1'b1, 5, {34'h0, c});
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ********
  // scenarios
  // ********
  initial begin
    {presetn, psel, penable, pwrite, tck, tms, tdi, protect, nvm_erase_done, stall, slow} = 11'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `JSB_OFF_CTRL, 32'h0);
    chk(rd, {30'h0, `JSB_CTRL_RST});
    apb(1'b0, 12'h010, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    chk(sb_rsp_ready, 1'b1);
    tk(1'b0, 1'b0);
    ir(`JSB_IR_WORD);
    chk(so[4:0], 5'h01);
    scan(1'b0, 35, {4'h0, 34'h40, 1'b0});
    scan(1'b0, 35, {7'h0, 32'hcafe0001});
    chk({last_addr, last_wdata}, {36'h100, 32'hcafe0001});
    stall <= 1'b1;
    ir(`JSB_IR_BLOCK);
    scan(1'b0, 34, {7'h0, 32'h11});
    scan(1'b0, 34, {7'h0, 32'h22});
    chk({sb_req_valid, sb_req_size, sb_req_write, sb_req_addr}, {1'b1, 2'h2, 1'b1, 36'h104});
    stall <= 1'b0;
    repeat (20) @(posedge pclk);
    chk({last_addr, last_wdata}, {36'h108, 32'h22});
    for (int s = 0; s < 3; s++) begin
      ir(`JSB_IR_SIZED);
      scan(1'b0, 39, {36'h200, s[1:0], 1'b1});
      ir(`JSB_IR_BLOCK);
      chk(last_addr, 36'h200 + (36'h1 << s));
      scan(1'b0, 34, 39'h0);
      if (s == 2) chk(so[33:0], {2'b00, 32'h204 ^ 32'h5a5a0000});
      chk(last_addr, 36'h200 + (36'h2 << s));
    end
    slow <= 1'b1;
    ir(`JSB_IR_WORD);
    scan(1'b0, 35, {4'h0, 34'h50, 1'b1});
    ir(`JSB_IR_CANCEL);
    chk(so[4:0], 5'h05);
    scan(1'b0, 1, 39'h0);
    chk(so[0], 1'b0);
    apb(1'b0, `JSB_OFF_STATUS, 32'h0);
    chk(rd[1], 1'b1);
    for (int k = 0; k < 1000 && rd[0] !== 1'b0; k++) apb(1'b0, `JSB_OFF_STATUS, 32'h0);
    chk(rd[0], 1'b0);
    slow <= 1'b0;
    ir(`JSB_IR_WORD);
    chk(so[4:0], 5'h09);
    scan(1'b0, 35, {4'h0, 34'h50, 1'b1});
    scan(1'b0, 35, 39'h0);
    chk(so[33:0], {2'b00, 32'h140 ^ 32'h5a5a0000});
    ir(`JSB_IR_SYNC);
    scan(1'b0, 16, 39'h0400);
    apb(1'b0, `JSB_OFF_SYNC, 32'h0);
    chk(rd > 32'h0 && rd < 32'h400, 1'b1);
    repeat (1100) @(posedge pclk);
    scan(1'b0, 16, 39'h0);
    chk(so[1:0], 2'b00);
    ir(`JSB_IR_DOMRST);
    scan(1'b0, 5, 39'h15);
    chk(domain_reset, 5'h15);
    scan(1'b0, 5, 39'h0);
    chk(domain_reset, 5'h0);
    ir(`JSB_IR_HALT);
    scan(1'b0, 1, 39'h1);
    chk(cpu_hold, 1'b1);
    repeat (10) tk(1'b0, 1'b0);
    protect <= 1'b1;
    ir(`JSB_IR_ERASE);
    chk(erase_cnt, 1);
    ir(`JSB_IR_ERASE);
    chk(so[4:0], 5'h05);
    nvm_erase_done <= 1'b1;
    @(posedge pclk);
    nvm_erase_done <= 1'b0;
    ir(`JSB_IR_HALT);
    chk(so[4:0], 5'h01);
    scan(1'b0, 1, 39'h0);
    chk({so[0], cpu_hold, rst_cnt[3:0]}, {1'b1, 1'b0, 4'h2});
    repeat (10) tk(1'b0, 1'b0);
    apb(1'b1, `JSB_OFF_CTRL, 32'h1);
    e0 = erase_cnt;
    ir(`JSB_IR_ERASE);
    ir(`JSB_IR_BYPASS);
    chk({so[4:0], erase_cnt}, {5'h01, e0});
    print_verdict();
  end
endmodule // jsb_instr_ext_tb_top

// ### sim/jsb_sbus_model.sv
// jsb_sbus_model.sv: service bus target answering every taken request in order
// assumes: pclk domain; bench sets stall and slow between operations
`timescale 1ns/1ps
module jsb_sbus_model (
  input wire pclk,
  input wire presetn,
  input wire stall,
  input wire slow,
  input wire sb_req_valid,
  output wire sb_req_ready,
  input wire [35:0] sb_req_addr,
  input wire sb_req_write,
  input wire [31:0] sb_req_wdata,
  output logic sb_rsp_valid,
  output logic [31:0] sb_rsp_rdata,
  output wire sb_rsp_err,
  output logic [35:0] last_addr,
  output logic [31:0] last_wdata
);
  logic [35:0] pend[$];
  int wait_cnt;
  // stall keeps words in the block's buffer
  assign sb_req_ready = !stall;
  assign sb_rsp_err = 1'b0;
  // in-order answers; read data wanders outside answers so stale values never match
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend.delete();
      wait_cnt <= 0;
      sb_rsp_valid <= 1'b0;
      sb_rsp_rdata <= 32'h0;
      last_addr <= 36'h0;
      last_wdata <= 32'h0;
    end else begin
      sb_rsp_valid <= 1'b0;
      sb_rsp_rdata <= ~sb_rsp_rdata;
      if (sb_req_valid && sb_req_ready) begin
        pend.push_back(sb_req_addr);
        last_addr <= sb_req_addr;
        if (sb_req_write) last_wdata <= sb_req_wdata;
      end
      if (pend.size() > 0 && wait_cnt >= (slow ? 2000 : 2)) begin
        sb_rsp_valid <= 1'b1;
        sb_rsp_rdata <= pend[0][31:0] ^ 32'h5a5a0000;
        void'(pend.pop_front());
        wait_cnt <= 0;
      end else if (pend.size() > 0) begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
endmodule // jsb_sbus_model
